// ===== src/lcd_cmd_regs.vh
// Command codes, reset values and field positions of the command decoder
// Operation
// - Opcode 0000xxxx loads low column nibble; zero after reset.
// - Opcode 0001xxxx loads high column nibble; zero after reset.
// - Opcode 00100xxx stores regulator gain ratio; resets to 100b.
// - Opcode 00101xxx sets buffer, regulator, booster enables; reset off.
// - Opcode 01xxxxxx loads six-bit first row pointer; resets to zero.
// - Contrast is 10000001 then a byte of six level bits; resets 100000b.
// - Remap bit chooses column 00h or 83h for first segment output.
// - Bias bit chooses 1/9 (reset) or 1/7 bias.
// - Entire-on and inverse flags set from bit 0; both clear at reset.
// - Opcode 1010111x sets panel enable; off at reset.
// - Opcode 1011xxxx loads page address, valid pages 0 to 8.
// - Opcode 1100xxxx bit 3 reverses row scan order; normal at reset.
// - Opcode 11100000 enters read-modify-write; reads keep column.
// - Opcode 11101110 leaves read-modify-write, restoring saved column.
// - Opcode 11100010 returns all settings to reset values.
// - Opcode 11100011 is a no-operation.
`ifndef LCD_CMD_REGS_VH
`define LCD_CMD_REGS_VH
`define LCD_OP_CONTRAST 8'h81
`define LCD_OP_RMW_ENTER 8'he0
`define LCD_OP_RMW_EXIT 8'hee
`define LCD_OP_SOFT_RESET 8'he2
`define LCD_OP_NOP 8'he3
`define LCD_RST_COLUMN 8'h00
`define LCD_RST_GAIN 3'h4
`define LCD_RST_POWER 3'h0
`define LCD_RST_FIRST_ROW 6'h00
`define LCD_RST_CONTRAST 6'h20
`define LCD_RST_PAGE 4'h0
`define LCD_COL_LAST 8'h83
`define LCD_PWR_BUF_BIT 0
`define LCD_PWR_REG_BIT 1
`define LCD_PWR_BOOST_BIT 2
`endif

// ===== src/lcd_flag_reg.v
// One settable flag with reset and software reset
module lcd_flag_reg (
    ref_clk,
    rst,
    softRst,
    load,
    din,
    q
);
input ref_clk;
input rst;
input softRst;
input load;
input din;
output q;
wire ref_clk;
wire rst;
wire softRst;
wire load;
wire din;
reg q;

always @(posedge ref_clk) begin
    if (rst || softRst) begin
        q <= 1'b0;
    end else if (load) begin
        q <= din;
    end
end
endmodule // lcd_flag_reg

// ===== src/lcd_column_ctr.v
// Column pointer with auto-increment and read-modify-write save/restore
`include "lcd_cmd_regs.vh"
module lcd_column_ctr (
    ref_clk,
    rst,
    softRst,
    loadLow,
    loadHigh,
    nibble,
    rmwEnter,
    rmwExit,
    dataWrite,
    dataRead,
    column,
    rmwActive
);
input ref_clk;
input rst;
input softRst;
input loadLow;
input loadHigh;
input [3:0] nibble;
input rmwEnter;
input rmwExit;
input dataWrite;
input dataRead;
output [7:0] column;
output rmwActive;
wire ref_clk;
wire rst;
wire softRst;
wire loadLow;
wire loadHigh;
wire [3:0] nibble;
wire rmwEnter;
wire rmwExit;
wire dataWrite;
wire dataRead;
wire [7:0] column;
wire rmwActive;
reg [7:0] column_q;
reg [7:0] saved_q;
reg rmw_q;
wire bump;

assign column = column_q;
assign rmwActive = rmw_q;
assign bump = dataWrite || (dataRead && !rmw_q);

always @(posedge ref_clk) begin
    if (rst || softRst) begin
        column_q <= `LCD_RST_COLUMN;
        saved_q <= `LCD_RST_COLUMN;
        rmw_q <= 1'b0;
    end else begin
        if (loadLow) begin
            column_q <= {column_q[7:4], nibble};
        end else if (loadHigh) begin
            column_q <= {nibble, column_q[3:0]};
        end else if (rmwExit && rmw_q) begin
            column_q <= saved_q;
        end else if (bump) begin
            column_q <= column_q + 8'h01;
        end
        if (rmwEnter && !rmw_q) begin
            rmw_q <= 1'b1;
            saved_q <= column_q;
        end else if (rmwExit) begin
            rmw_q <= 1'b0;
        end
    end
end
endmodule // lcd_column_ctr

// ===== src/lcd_cmd_decoder.v
// Command byte decoder holding the display settings
`include "lcd_cmd_regs.vh"
module lcd_cmd_decoder (
    ref_clk,
    rst,
    cmdValid,
    cmdByte,
    dataWrite,
    dataRead,
    columnPointer,
    pageAddress,
    firstRowPointer,
    contrastLevel,
    regulatorGainRatio,
    powerEnables,
    segmentRemap,
    biasAlternate,
    entireOn,
    inverseVideo,
    panelOn,
    comReverse,
    rmwActive
);
input ref_clk;
input rst;
input cmdValid;
input [7:0] cmdByte;
input dataWrite;
input dataRead;
output [7:0] columnPointer;
output [3:0] pageAddress;
output [5:0] firstRowPointer;
output [5:0] contrastLevel;
output [2:0] regulatorGainRatio;
output [2:0] powerEnables;
output segmentRemap;
output biasAlternate;
output entireOn;
output inverseVideo;
output panelOn;
output comReverse;
output rmwActive;
wire ref_clk;
wire rst;
wire cmdValid;
wire [7:0] cmdByte;
wire dataWrite;
wire dataRead;
wire [7:0] columnPointer;
wire rmwActive;
wire segmentRemap;
wire biasAlternate;
wire entireOn;
wire inverseVideo;
wire panelOn;
wire comReverse;
wire [3:0] pageAddress;
wire [5:0] firstRowPointer;
wire [5:0] contrastLevel;
wire [2:0] regulatorGainRatio;
wire [2:0] powerEnables;
wire [2:0] powerBits;
reg [3:0] page_q;
reg [3:0] page_d;
reg [5:0] firstRow_q;
reg [5:0] firstRow_d;
reg [5:0] contrast_q;
reg [5:0] contrast_d;
reg [2:0] gain_q;
reg [2:0] gain_d;

// ----------------------------------------
// Opcode decode
// ----------------------------------------
wire cmdTake;
wire argPending;
reg softRst;
reg isLowCol;
reg isHighCol;
reg isGain;
reg isPower;
reg isFirstRow;
reg isContrast;
reg isRemap;
reg isBias;
reg isEntire;
reg isInverse;
reg isPanel;
reg isPage;
reg isScan;
reg isRmwEnter;
reg isRmwExit;

// The byte after the contrast opcode is an argument, not an opcode
assign cmdTake = cmdValid && !argPending;

// Opcode classes never overlap, so the order of the chain is free
always @* begin
    softRst = 1'b0;
    isLowCol = 1'b0;
    isHighCol = 1'b0;
    isGain = 1'b0;
    isPower = 1'b0;
    isFirstRow = 1'b0;
    isContrast = 1'b0;
    isRemap = 1'b0;
    isBias = 1'b0;
    isEntire = 1'b0;
    isInverse = 1'b0;
    isPanel = 1'b0;
    isPage = 1'b0;
    isScan = 1'b0;
    isRmwEnter = 1'b0;
    isRmwExit = 1'b0;
    // Nothing is decoded while a contrast argument is expected
    if (cmdTake) begin
        if (cmdByte[7:4] == 4'h0) begin
            isLowCol = 1'b1;
        end else if (cmdByte[7:4] == 4'h1) begin
            isHighCol = 1'b1;
        end else if (cmdByte[7:3] == 5'h04) begin
            isGain = 1'b1;
        end else if (cmdByte[7:3] == 5'h05) begin
            isPower = 1'b1;
        end else if (cmdByte[7:6] == 2'h1) begin
            isFirstRow = 1'b1;
        end else if (cmdByte == `LCD_OP_CONTRAST) begin
            isContrast = 1'b1;
        end else if (cmdByte[7:1] == 7'h50) begin
            isRemap = 1'b1;
        end else if (cmdByte[7:1] == 7'h51) begin
            isBias = 1'b1;
        end else if (cmdByte[7:1] == 7'h52) begin
            isEntire = 1'b1;
        end else if (cmdByte[7:1] == 7'h53) begin
            isInverse = 1'b1;
        end else if (cmdByte[7:1] == 7'h57) begin
            isPanel = 1'b1;
        end else if (cmdByte[7:4] == 4'hb) begin
            isPage = 1'b1;
        end else if (cmdByte[7:4] == 4'hc) begin
            isScan = 1'b1;
        end else if (cmdByte == `LCD_OP_RMW_ENTER) begin
            isRmwEnter = 1'b1;
        end else if (cmdByte == `LCD_OP_RMW_EXIT) begin
            isRmwExit = 1'b1;
        end else if (cmdByte == `LCD_OP_SOFT_RESET) begin
            softRst = 1'b1;
        end else if (cmdByte == `LCD_OP_NOP) begin
            softRst = 1'b0;
        end else begin
            softRst = 1'b0;
        end
    end
end

// ----------------------------------------
// Contrast argument framing
// ----------------------------------------
// Opcode byte expected, or contrast argument expected
localparam [1:0] ST_OPCODE = 2'b01;
localparam [1:0] ST_ARGUMENT = 2'b10;
reg [1:0] state_q;
reg [1:0] state_d;

assign argPending = (state_q == ST_ARGUMENT);

always @* begin
    state_d = state_q;
    case (state_q)
        ST_OPCODE: begin
            if (isContrast) begin
                state_d = ST_ARGUMENT;
            end
        end
        ST_ARGUMENT: begin
            if (cmdValid) begin
                state_d = ST_OPCODE;
            end
        end
        default: begin
            state_d = ST_OPCODE;
        end
    endcase
end

always @(posedge ref_clk) begin
    if (rst || softRst) begin
        state_q <= ST_OPCODE;
    end else begin
        state_q <= state_d;
    end
end

// ----------------------------------------
// Multi-bit settings
// ----------------------------------------
always @* begin
    page_d = page_q;
    firstRow_d = firstRow_q;
    contrast_d = contrast_q;
    gain_d = gain_q;
    if (argPending && cmdValid) begin
        contrast_d = cmdByte[5:0];
    end
    if (isGain) begin
        gain_d = cmdByte[2:0];
    end
    if (isFirstRow) begin
        firstRow_d = cmdByte[5:0];
    end
    if (isPage) begin
        page_d = cmdByte[3:0];
    end
end

always @(posedge ref_clk) begin
    if (rst || softRst) begin
        page_q <= `LCD_RST_PAGE;
        firstRow_q <= `LCD_RST_FIRST_ROW;
        contrast_q <= `LCD_RST_CONTRAST;
        gain_q <= `LCD_RST_GAIN;
    end else begin
        page_q <= page_d;
        firstRow_q <= firstRow_d;
        contrast_q <= contrast_d;
        gain_q <= gain_d;
    end
end

// ----------------------------------------
// Column pointer and mode flags
// ----------------------------------------
lcd_column_ctr u_column (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .loadLow(isLowCol),
    .loadHigh(isHighCol),
    .nibble(cmdByte[3:0]),
    .rmwEnter(isRmwEnter),
    .rmwExit(isRmwExit),
    .dataWrite(dataWrite),
    .dataRead(dataRead),
    .column(columnPointer),
    .rmwActive(rmwActive)
);

lcd_flag_reg u_remap (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isRemap),
    .din(cmdByte[0]),
    .q(segmentRemap)
);

lcd_flag_reg u_bias (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isBias),
    .din(cmdByte[0]),
    .q(biasAlternate)
);

lcd_flag_reg u_entire (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isEntire),
    .din(cmdByte[0]),
    .q(entireOn)
);

lcd_flag_reg u_inverse (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isInverse),
    .din(cmdByte[0]),
    .q(inverseVideo)
);

lcd_flag_reg u_panel (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isPanel),
    .din(cmdByte[0]),
    .q(panelOn)
);

lcd_flag_reg u_scan (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isScan),
    .din(cmdByte[3]),
    .q(comReverse)
);

// ----------------------------------------
// Power enables
// ----------------------------------------
// All three enables load together from one command
lcd_flag_reg u_buffer (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isPower),
    .din(cmdByte[`LCD_PWR_BUF_BIT]),
    .q(powerBits[`LCD_PWR_BUF_BIT])
);

lcd_flag_reg u_regulator (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isPower),
    .din(cmdByte[`LCD_PWR_REG_BIT]),
    .q(powerBits[`LCD_PWR_REG_BIT])
);

lcd_flag_reg u_booster (
    .ref_clk(ref_clk),
    .rst(rst),
    .softRst(softRst),
    .load(isPower),
    .din(cmdByte[`LCD_PWR_BOOST_BIT]),
    .q(powerBits[`LCD_PWR_BOOST_BIT])
);

// ----------------------------------------
// Registered outputs
// ----------------------------------------
assign pageAddress = page_q;
assign firstRowPointer = firstRow_q;
assign contrastLevel = contrast_q;
assign regulatorGainRatio = gain_q;
assign powerEnables = powerBits;
endmodule // lcd_cmd_decoder

// ===== test/lcd_cmd_decoder_assertions.sv
// Concurrent checks on the command decoder ports
module lcd_cmd_checker (
    input wire ref_clk,
    input wire rst,
    input wire cmdValid,
    input wire [7:0] cmdByte,
    input wire dataWrite,
    input wire dataRead,
    input wire [7:0] columnPointer,
    input wire [5:0] firstRowPointer,
    input wire [5:0] contrastLevel,
    input wire [2:0] regulatorGainRatio,
    input wire [2:0] powerEnables,
    input wire panelOn,
    input wire rmwActive
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Contrast argument tracking
    // ----------------------------------------
    logic pend_q;
    wire op = cmdValid && !pend_q;
    always @(posedge ref_clk) begin
        if (rst) pend_q <= 1'b0;
        else if (cmdValid) pend_q <= op && cmdByte == 8'h81;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence contrastPair;
        op && cmdByte == 8'h81 ##1 !cmdValid ##1 cmdValid;
    endsequence
    sequence rmwRead;
        rmwActive && dataRead && !dataWrite && !cmdValid;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    col_low_a: assert property (op && cmdByte[7:4] == 4'h0
        |=> columnPointer[3:0] == $past(cmdByte[3:0])) else $error("low");
    col_high_a: assert property (op && cmdByte[7:4] == 4'h1
        |=> columnPointer[7:4] == $past(cmdByte[3:0])) else $error("high");
    gain_load_a: assert property (op && cmdByte[7:3] == 5'h04
        |=> regulatorGainRatio == $past(cmdByte[2:0])) else $error("gain");
    power_load_a: assert property (op && cmdByte[7:3] == 5'h05
        |=> powerEnables == $past(cmdByte[2:0])) else $error("power");
    row_load_a: assert property (op && cmdByte[7:6] == 2'h1
        |=> firstRowPointer == $past(cmdByte[5:0])) else $error("row");
    contrast_arg_a: assert property (contrastPair
        |=> contrastLevel == $past(cmdByte[5:0])) else $error("contrast");
    panel_set_a: assert property (op && cmdByte[7:1] == 7'h57
        |=> panelOn == $past(cmdByte[0])) else $error("panel");
    rmw_read_a: assert property (rmwRead
        |=> $stable(columnPointer)) else $error("rmw read");
    soft_reset_a: assert property (op && cmdByte == 8'he2
        |=> contrastLevel == 6'h20 && regulatorGainRatio == 3'h4
        && !rmwActive) else $error("soft reset");
endmodule // lcd_cmd_checker
bind lcd_cmd_decoder lcd_cmd_checker lcd_cmd_checker_inst (.*);

// ===== test/lcd_host_model.sv
// Host side model that writes command bytes
module lcd_host_model (
    input wire ref_clk,
    output logic cmdValid,
    output logic [7:0] cmdByte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmdValid = 1'b0;
    initial cmdByte = 8'h00;
    task automatic sendCmd(input logic [7:0] b);
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdByte <= b;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        cmdByte <= ~b;
    endtask
endmodule // lcd_host_model

// ===== test/lcd_cmd_decoder_tb_top.sv
// Self-checking bench for the command decoder
module lcd_cmd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic dataWrite = 1'b0;
    logic dataRead = 1'b0;
    wire cmdValid, segmentRemap, biasAlternate, entireOn, inverseVideo;
    wire panelOn, comReverse, rmwActive;
    wire [7:0] cmdByte, columnPointer;
    wire [3:0] pageAddress;
    wire [5:0] firstRowPointer, contrastLevel;
    wire [2:0] regulatorGainRatio, powerEnables;
    wire [6:0] flags = {rmwActive, comReverse, panelOn, inverseVideo,
        entireOn, biasAlternate, segmentRemap};
    logic [7:0] mCol, mSave;
    logic [3:0] mPage;
    logic [5:0] mRow, mCon, mFl;
    logic [2:0] mGain, mPwr;
    logic mRmw, mPend;
    int mismatches = 0;
    int samples_checked = 0;
    int i;
    localparam logic [7:0] DIR [8] = '{8'h81, 8'he2, 8'h0f, 8'h18,
        8'he0, 8'he0, 8'he3, 8'hf7};
    lcd_host_model lcd_host_model_inst (.*);
    lcd_cmd_decoder lcd_cmd_decoder_inst (.*);
    initial forever #4 ref_clk = ~ref_clk;
    // ----------------------------------------
    // Model and checks
    // ----------------------------------------
    task automatic modelReset;
        {mCol, mSave, mPage, mRow, mCon, mGain, mPwr, mFl, mRmw, mPend} =
            {16'h0, 4'h0, 6'h0, 6'h20, 3'h4, 3'h0, 6'h0, 2'h0};
    endtask
    task automatic chk(input string n, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic chkAll;
        #1;
        chk("col", columnPointer, mCol);
        chk("page", pageAddress, mPage);
        chk("row", firstRowPointer, mRow);
        chk("con", contrastLevel, mCon);
        chk("gain", regulatorGainRatio, mGain);
        chk("pwr", powerEnables, mPwr);
        chk("flag", flags, {mRmw, mFl});
    endtask
    task automatic cmd(input logic [7:0] b);
        lcd_host_model_inst.sendCmd(b);
        if (mPend) {mPend, mCon} = {1'b0, b[5:0]};
        else casez (b)
            8'b0000????: mCol[3:0] = b[3:0];
            8'b0001????: mCol[7:4] = b[3:0];
            8'b00100???: mGain = b[2:0];
            8'b00101???: mPwr = b[2:0];
            8'b01??????: mRow = b[5:0];
            8'h81: mPend = 1'b1;
            8'b1010000?: mFl[0] = b[0];
            8'b1010001?: mFl[1] = b[0];
            8'b1010010?: mFl[2] = b[0];
            8'b1010011?: mFl[3] = b[0];
            8'b1010111?: mFl[4] = b[0];
            8'b1011????: mPage = b[3:0];
            8'b1100????: mFl[5] = b[3];
            8'he0: if (!mRmw) {mRmw, mSave} = {1'b1, mCol};
            8'hee: if (mRmw) {mRmw, mCol} = {1'b0, mSave};
            8'he2: modelReset();
            default: ;
        endcase
        chkAll();
    endtask
    task automatic acc(input logic w, r);
        @(posedge ref_clk);
        dataWrite <= w;
        dataRead <= r;
        @(posedge ref_clk);
        dataWrite <= 1'b0;
        dataRead <= 1'b0;
        if (w || (r && !mRmw)) mCol = mCol + 8'h01;
        chkAll();
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h1ca7));
        modelReset();
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        chkAll();
        for (i = 0; i < 8; i++) cmd(DIR[i]);
        acc(1'b0, 1'b1);
        acc(1'b1, 1'b0);
        acc(1'b0, 1'b1);
        cmd(8'hee);
        cmd(8'hee);
        acc(1'b0, 1'b1);
        // Reset while a contrast argument is pending clears the pending
        cmd(8'h81);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        modelReset();
        chkAll();
        cmd(8'h05);
        for (i = 0; i < 256; i++) cmd(8'(i));
        for (i = 0; i < 400; i++) begin
            if ($urandom_range(3) == 0) acc(1'($urandom), 1'($urandom));
            else cmd(8'($urandom));
        end
        close_out();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end
endmodule // lcd_cmd_decoder_tb_top
